// *** design/fcts_regs.svh ***
`ifndef FCTS_REGS_SVH
`define FCTS_REGS_SVH
`define FCTS_ADDR_CTRL        4'h0
`define FCTS_ADDR_TERMINAL    4'h1
`define FCTS_ADDR_FILTER      4'h2
`define FCTS_ADDR_RISE_ACK    4'h3
`define FCTS_ADDR_FALL_ACK    4'h4
`define FCTS_ADDR_COUNT       4'h5
`define FCTS_ADDR_STATUS      4'h6
`define FCTS_ADDR_IRQ_STAT    4'h7
`define FCTS_ADDR_IRQ_MASK    4'h8
`define FCTS_ADDR_RISE_STAMP  4'h9
`define FCTS_ADDR_FALL_STAMP  4'ha
`define FCTS_CTRL_CLEAR_BIT   0
`define FCTS_CTRL_WRAPCLR_BIT 1
`define FCTS_CTRL_ERASE_BIT   2
`define FCTS_CTRL_WRAPSEL_BIT 3
`define FCTS_CTRL_HOLD_BIT    4
`define FCTS_CODE_MIN         8'h05
`define FCTS_CODE_MAX         8'h12
`define FCTS_CODE_RESET       8'h05
`define FCTS_MAX_COUNT        32'h7fffffff
`define FCTS_CLK_MHZ          200
`define FCTS_UNSUPPORTED_IRQ  3
`endif

// *** design/fcts_pkg.sv ***
package fcts_pkg;
    typedef struct packed {
        logic [31:0] value;
        logic [15:0] seq;
        logic        full;
    } fcts_stamp_type;

    typedef struct packed {
        logic [7:0]  onCode;
        logic [7:0]  offCode;
        logic        wrapAtTerminal;
        logic        holdStamps;
    } fcts_cfg_type;

    typedef struct packed {
        logic [31:0] count;
        logic        wrapFlag;
        logic        limitFlag;
        logic        filtCnt;
        logic        filtPt;
    } fcts_cnt_type;
endpackage

// *** design/fcts_ctrl.sv ***
`timescale 1ns/1ps
`include "fcts_regs.svh"
module fcts_ctrl
    import fcts_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        counterIn,
    input  wire logic        pointIn,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [31:0] rdData,
    output logic             irq
);
    // Filter delay per code in microseconds; codes 5..18
    function automatic logic [31:0] codeCycles(input logic [7:0] code);
        logic [31:0] us;
        us = 32'h0;
        unique case (code)
            8'h06: us = 32'd5;
            8'h07: us = 32'd10;
            8'h08: us = 32'd20;
            8'h09: us = 32'd50;
            8'h0a: us = 32'd100;
            8'h0b: us = 32'd200;
            8'h0c: us = 32'd500;
            8'h0d: us = 32'd1000;
            8'h0e: us = 32'd2000;
            8'h0f: us = 32'd5000;
            8'h10: us = 32'd10000;
            8'h11: us = 32'd20000;
            8'h12: us = 32'd50000;
            default: us = 32'h0;
        endcase
        return 32'(us * `FCTS_CLK_MHZ);
    endfunction

    // Code set is contiguous, so a range test is enough
    function automatic logic codeOk(input logic [7:0] code);
        return (code >= `FCTS_CODE_MIN) && (code <= `FCTS_CODE_MAX);
    endfunction

    typedef struct packed {
        fcts_cfg_type   cfg;
        fcts_cnt_type   cnt;
        logic [31:0]    terminal;
        logic [31:0]    cntTimer;
        logic [31:0]    ptTimer;
        logic [31:0]    stampTime;
        fcts_stamp_type rise;
        fcts_stamp_type fall;
        logic [15:0]    riseAck;
        logic [15:0]    fallAck;
        logic [2:0]     ctlPrev;
        logic [3:0]     irqStat;
        logic [3:0]     irqMask;
        logic [31:0]    rdData;
    } fcts_state_type;

    fcts_state_type st_r;
    fcts_state_type st_nxt;

    // Next value of every register is formed here; one flop bank below holds it
    always_comb begin
        logic [2:0]  ctlNow;
        logic [2:0]  ctlRise;
        logic        cntOnDone;
        logic        cntOffDone;
        logic        ptOnDone;
        logic        ptOffDone;
        logic        cntStep;
        logic        ptRise;
        logic        ptFall;
        logic        wrapEv;
        logic        badCode;
        logic [31:0] cntNext;
        st_nxt = st_r;
        ctlNow = st_r.ctlPrev;
        ctlRise = 3'h0;
        cntOnDone = 1'b0;
        cntOffDone = 1'b0;
        ptOnDone = 1'b0;
        ptOffDone = 1'b0;
        badCode = 1'b0;
        cntStep = 1'b0;
        wrapEv = 1'b0;
        ptRise = 1'b0;
        ptFall = 1'b0;
        cntNext = st_r.cnt.count;
        // Free-running stamp clock wraps silently
        st_nxt.stampTime = st_r.stampTime + 32'h1;
        st_nxt.rdData = 32'h0;

        if (wrStb) begin
            unique case (addr)
                `FCTS_ADDR_CTRL: begin
                    ctlNow[2] = wrData[`FCTS_CTRL_ERASE_BIT];
                    ctlNow[1] = wrData[`FCTS_CTRL_WRAPCLR_BIT];
                    ctlNow[0] = wrData[`FCTS_CTRL_CLEAR_BIT];
                    st_nxt.cfg.wrapAtTerminal = wrData[`FCTS_CTRL_WRAPSEL_BIT];
                    st_nxt.cfg.holdStamps = wrData[`FCTS_CTRL_HOLD_BIT];
                end
                `FCTS_ADDR_TERMINAL: begin
                    st_nxt.terminal = {1'b0, wrData[30:0]};
                end
                `FCTS_ADDR_FILTER: begin
                    st_nxt.cfg.onCode = wrData[7:0];
                    st_nxt.cfg.offCode = wrData[15:8];
                end
                `FCTS_ADDR_RISE_ACK: begin
                    st_nxt.riseAck = wrData[15:0];
                end
                `FCTS_ADDR_FALL_ACK: begin
                    st_nxt.fallAck = wrData[15:0];
                end
                `FCTS_ADDR_IRQ_MASK: begin
                    st_nxt.irqMask = wrData[3:0];
                end
                // Writes to read-only or unmapped words are ignored
                default: ;
            endcase
        end
        // Edges are taken against the last written level, so holding a bit high does nothing
        ctlRise = ctlNow & ~st_r.ctlPrev;
        st_nxt.ctlPrev = ctlNow;

        // Unsupported codes keep the last reported level rather than guess a delay
        badCode = !codeOk(st_r.cfg.onCode) || !codeOk(st_r.cfg.offCode);

        // Counter input filter; timer restarts whenever raw matches the reported level
        cntOnDone = st_r.cntTimer >= codeCycles(st_r.cfg.onCode);
        cntOffDone = st_r.cntTimer >= codeCycles(st_r.cfg.offCode);
        if (badCode || counterIn == st_r.cnt.filtCnt) begin
            st_nxt.cntTimer = 32'h0;
        end else if ((counterIn && cntOnDone) || (!counterIn && cntOffDone)) begin
            st_nxt.cnt.filtCnt = counterIn;
            st_nxt.cntTimer = 32'h0;
            cntStep = counterIn;
        end else begin
            st_nxt.cntTimer = st_r.cntTimer + 32'h1;
        end

        // Point filter shares the codes; a bounce restarts its timer
        ptOnDone = st_r.ptTimer >= codeCycles(st_r.cfg.onCode);
        ptOffDone = st_r.ptTimer >= codeCycles(st_r.cfg.offCode);
        if (badCode || pointIn == st_r.cnt.filtPt) begin
            st_nxt.ptTimer = 32'h0;
        end else if ((pointIn && ptOnDone) || (!pointIn && ptOffDone)) begin
            st_nxt.cnt.filtPt = pointIn;
            st_nxt.ptTimer = 32'h0;
            ptRise = pointIn;
            ptFall = !pointIn;
        end else begin
            st_nxt.ptTimer = st_r.ptTimer + 32'h1;
        end

        // Preset mode: an increment reaching the terminal wraps, so terminal 0 wraps every step
        if (cntStep) begin
            if (st_r.cfg.wrapAtTerminal) begin
                cntNext = st_r.cnt.count + 32'h1;
                if (cntNext >= st_r.terminal) begin
                    cntNext = 32'h0;
                    wrapEv = 1'b1;
                end
            end else if (st_r.cnt.count == `FCTS_MAX_COUNT) begin
                cntNext = 32'h0;
                wrapEv = 1'b1;
            end else begin
                cntNext = st_r.cnt.count + 32'h1;
            end
        end else if (st_r.cfg.wrapAtTerminal && st_r.cnt.count >= st_r.terminal) begin
            cntNext = 32'h0;
        end
        st_nxt.cnt.count = cntNext;
        if (wrapEv) begin
            st_nxt.cnt.wrapFlag = 1'b1;
        end else if (ctlRise[1]) begin
            st_nxt.cnt.wrapFlag = 1'b0;
        end
        if (ctlRise[0]) begin
            st_nxt.cnt.count = 32'h0;
            st_nxt.cnt.wrapFlag = 1'b0;
        end
        // Limit follows the new count and mode so it never lags a write
        st_nxt.cnt.limitFlag = !st_nxt.cfg.wrapAtTerminal
                               && st_nxt.cnt.count >= st_nxt.terminal;

        // An acknowledged stamp frees its slot for the next capture
        if (st_r.rise.full && st_r.riseAck == st_r.rise.seq) begin
            st_nxt.rise.full = 1'b0;
        end
        if (st_r.fall.full && st_r.fallAck == st_r.fall.seq) begin
            st_nxt.fall.full = 1'b0;
        end
        // Hold test uses the freed slot, so an ack and an edge in one cycle still capture
        // Sequence numbers wrap freely; the host must echo them exactly
        if (ptRise && !(st_r.cfg.holdStamps && st_nxt.rise.full)) begin
            st_nxt.rise.value = st_r.stampTime;
            st_nxt.rise.seq = st_r.rise.seq + 16'h1;
            st_nxt.rise.full = 1'b1;
        end
        if (ptFall && !(st_r.cfg.holdStamps && st_nxt.fall.full)) begin
            st_nxt.fall.value = st_r.stampTime;
            st_nxt.fall.seq = st_r.fall.seq + 16'h1;
            st_nxt.fall.full = 1'b1;
        end
        // Erase wins over a capture in the same cycle
        if (ctlRise[2]) begin
            st_nxt.rise.value = 32'h0;
            st_nxt.rise.full = 1'b0;
            st_nxt.fall.value = 32'h0;
            st_nxt.fall.full = 1'b0;
        end

        // Read data stand for one cycle only and are zero otherwise
        if (rdStb) begin
            unique case (addr)
                `FCTS_ADDR_CTRL: begin
                    st_nxt.rdData = {27'h0, st_r.cfg.holdStamps, st_r.cfg.wrapAtTerminal,
                                     st_r.ctlPrev};
                end
                `FCTS_ADDR_TERMINAL: begin
                    st_nxt.rdData = st_r.terminal;
                end
                `FCTS_ADDR_FILTER: begin
                    st_nxt.rdData = {16'h0, st_r.cfg.offCode, st_r.cfg.onCode};
                end
                `FCTS_ADDR_RISE_ACK: begin
                    st_nxt.rdData = {16'h0, st_r.riseAck};
                end
                `FCTS_ADDR_FALL_ACK: begin
                    st_nxt.rdData = {16'h0, st_r.fallAck};
                end
                `FCTS_ADDR_COUNT: begin
                    st_nxt.rdData = st_r.cnt.count;
                end
                `FCTS_ADDR_STATUS: begin
                    st_nxt.rdData = {26'h0, st_r.fall.full, st_r.rise.full, st_r.cnt.filtPt,
                                     st_r.cnt.filtCnt, st_r.cnt.limitFlag, st_r.cnt.wrapFlag};
                end
                `FCTS_ADDR_IRQ_STAT: begin
                    st_nxt.rdData = {28'h0, st_r.irqStat};
                end
                `FCTS_ADDR_IRQ_MASK: begin
                    st_nxt.rdData = {28'h0, st_r.irqMask};
                end
                `FCTS_ADDR_RISE_STAMP: begin
                    st_nxt.rdData = st_r.rise.value;
                end
                `FCTS_ADDR_FALL_STAMP: begin
                    st_nxt.rdData = st_r.fall.value;
                end
                default: begin
                    st_nxt.rdData = 32'h0;
                end
            endcase
        end

        // Read clears status, but an event in the same cycle still lands
        if (rdStb && addr == `FCTS_ADDR_IRQ_STAT) begin
            st_nxt.irqStat = 4'h0;
        end
        st_nxt.irqStat = st_nxt.irqStat | {badCode, ptFall, ptRise, wrapEv};
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            // Codes come up at no delay, so levels pass straight after reset
            st_r <= '0;
            st_r.cfg.onCode <= `FCTS_CODE_RESET;
            st_r.cfg.offCode <= `FCTS_CODE_RESET;
            st_r.terminal <= 32'h0;
            st_r.irqMask <= 4'h0;
            st_r.rdData <= 32'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdData = st_r.rdData;
    // Level interrupt is a gate decode of flopped status and mask, not a flop of its own
    assign irq = |(st_r.irqStat & st_r.irqMask);
endmodule

// *** testbench/fcts_ctrl_sva.sv ***
`timescale 1ns/1ps
`include "fcts_regs.svh"
module fcts_ctrl_sva
    import fcts_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        counterIn,
    input wire logic        pointIn,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wrData,
    input wire logic        wrStb,
    input wire logic        rdStb,
    input wire logic [31:0] rdData,
    input wire logic        irq
);
    logic [30:0] term_r;
    logic [4:0]  ctrl_r;
    logic        mask0_r;
    logic [1:0]  age_r;
    logic        rdLast_r;
    logic [3:0]  rdAddr_r;
    wire         wrCtl = wrStb && addr == `FCTS_ADDR_CTRL;
    wire         rdSta = rdStb && addr == `FCTS_ADDR_STATUS;
    wire         ansCnt = rdLast_r && rdAddr_r == `FCTS_ADDR_COUNT;
    // Settle count keeps the mask and preset checks off the cycles right after any write
    always_ff @(posedge mclk) begin
        if (rst) begin
            term_r   <= '0;
            ctrl_r   <= '0;
            mask0_r  <= 1'b1;
            age_r    <= 2'h0;
            rdLast_r <= 1'b0;
            rdAddr_r <= 4'h0;
        end else begin
            if (wrCtl) ctrl_r <= wrData[4:0];
            if (wrStb && addr == `FCTS_ADDR_TERMINAL) term_r <= wrData[30:0];
            if (wrStb && addr == `FCTS_ADDR_IRQ_MASK) mask0_r <= wrData == 32'h0;
            age_r    <= wrStb ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
            rdLast_r <= rdStb;
            rdAddr_r <= addr;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_rd_idle: assert property (!rdLast_r |-> rdData == 32'h0)
        else $error("read data outside answer cycle");
    chk_unmapped_rd: assert property (rdLast_r && rdAddr_r > `FCTS_ADDR_FALL_STAMP |-> rdData == 32'h0)
        else $error("unmapped read gave data");
    chk_mask_silent: assert property (mask0_r && age_r == 2'h3 |-> !irq)
        else $error("irq with all masked");
    chk_preset_bound: assert property (ansCnt && ctrl_r[3] && age_r == 2'h3
        |-> rdData < {1'b0, term_r} || rdData == 32'h0)
        else $error("preset count at or above terminal");
    chk_preset_nolimit: assert property (rdLast_r && rdAddr_r == `FCTS_ADDR_STATUS
        && ctrl_r[3] && age_r == 2'h3 |-> !rdData[1])
        else $error("limit flag in preset mode");
    chk_clear_count: assert property (wrCtl && wrData[0] && !ctrl_r[0]
        ##2 rdStb && addr == `FCTS_ADDR_COUNT |=> rdData == 32'h0)
        else $error("count not cleared");
    chk_clear_wrap: assert property (wrCtl && wrData[0] && !ctrl_r[0] ##2 rdSta |=> !rdData[0])
        else $error("wrap not cleared by clear");
    chk_wrap_ack: assert property (wrCtl && wrData[1] && !ctrl_r[1] ##2 rdSta |=> !rdData[0])
        else $error("wrap not cleared by ack");
    cover property (irq ##1 !irq);
    cover property (ansCnt && ctrl_r[3]);
    cover property (rdLast_r && rdAddr_r == `FCTS_ADDR_STATUS && rdData[0]);
endmodule

bind fcts_ctrl fcts_ctrl_sva u_sva (.mclk(mclk), .rst(rst), .counterIn(counterIn), .pointIn(pointIn),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq));

// *** testbench/fcts_field_model.sv ***
`timescale 1ns/1ps
module fcts_field_model (
    input  wire logic mclk,
    output logic      counterIn,
    output logic      pointIn
);
    initial begin
        counterIn = 1'b0;
        pointIn   = 1'b0;
    end
    // Clean contact levels only; bounce is not modelled
    task automatic pulse(input bit cnt, input int hi);
        @(posedge mclk);
        if (cnt) counterIn <= 1'b1;
        else pointIn <= 1'b1;
        repeat (hi) @(posedge mclk);
        counterIn <= 1'b0;
        pointIn   <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
endmodule

// *** testbench/fcts_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "fcts_regs.svh"
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin numErrors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module fcts_ctrl_tb;
    logic        mclk;
    logic        rst;
    logic        counterIn;
    logic        pointIn;
    logic [3:0]  addr;
    logic [31:0] wrData;
    logic        wrStb;
    logic        rdStb;
    logic [31:0] rdData;
    logic        irq;
    logic [31:0] d;
    logic [31:0] v1 [2];
    int          numErrors = 0;
    int          checks = 0;
    int          cyc = 0;
    fcts_ctrl dut (.mclk(mclk), .rst(rst), .counterIn(counterIn), .pointIn(pointIn), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq));
    fcts_field_model u_field (.mclk(mclk), .counterIn(counterIn), .pointIn(pointIn));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr   <= a;
        wrData <= v;
        wrStb  <= 1'b1;
        @(posedge mclk);
        wrStb  <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1 v = rdData;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHECK(v & m, e)
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 10000) begin
            numErrors++;
            stop_test;
        end
    end
    initial begin
        rst    = 1'b1;
        addr   = 4'h0;
        wrData = 32'h0;
        wrStb  = 1'b0;
        rdStb  = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        wr(`FCTS_ADDR_FILTER, 32'h00000506);
        u_field.pulse(1, 990);
        rc(`FCTS_ADDR_COUNT, 32'hffffffff, 32'h0);
        u_field.pulse(1, 1010);
        rc(`FCTS_ADDR_COUNT, 32'hffffffff, 32'h1);
        rc(4'hf, 32'hffffffff, 32'h0);
        wr(`FCTS_ADDR_FILTER, 32'h00000505);
        wr(`FCTS_ADDR_TERMINAL, 32'h00000002);
        rc(`FCTS_ADDR_STATUS, 32'h2, 32'h0);
        u_field.pulse(1, 4);
        rc(`FCTS_ADDR_STATUS, 32'h2, 32'h2);
        u_field.pulse(1, 4);
        rc(`FCTS_ADDR_COUNT, 32'hffffffff, 32'h3);
        wr(`FCTS_ADDR_CTRL, 32'h1);
        rc(`FCTS_ADDR_COUNT, 32'hffffffff, 32'h0);
        wr(`FCTS_ADDR_IRQ_MASK, 32'h1);
        wr(`FCTS_ADDR_CTRL, 32'h8);
        u_field.pulse(1, 4);
        u_field.pulse(1, 4);
        rc(`FCTS_ADDR_COUNT, 32'hffffffff, 32'h0);
        rc(`FCTS_ADDR_STATUS, 32'h3, 32'h1);
        `CHECK(irq, 1'b1)
        rc(`FCTS_ADDR_IRQ_STAT, 32'h1, 32'h1);
        @(posedge mclk);
        #1 `CHECK(irq, 1'b0)
        wr(`FCTS_ADDR_CTRL, 32'ha);
        rc(`FCTS_ADDR_STATUS, 32'h1, 32'h0);
        u_field.pulse(1, 4);
        u_field.pulse(1, 4);
        wr(`FCTS_ADDR_CTRL, 32'h9);
        rc(`FCTS_ADDR_STATUS, 32'h1, 32'h0);
        wr(`FCTS_ADDR_FILTER, 32'h00000504);
        rc(`FCTS_ADDR_IRQ_STAT, 32'h8, 32'h8);
        wr(`FCTS_ADDR_FILTER, 32'h00000505);
        wr(`FCTS_ADDR_CTRL, 32'h18);
        u_field.pulse(0, 4);
        rc(`FCTS_ADDR_STATUS, 32'h30, 32'h30);
        for (int k = 0; k < 2; k++) rd(4'(`FCTS_ADDR_RISE_STAMP + k), v1[k]);
        u_field.pulse(0, 4);
        for (int k = 0; k < 2; k++) rc(4'(`FCTS_ADDR_RISE_STAMP + k), 32'hffffffff, v1[k]);
        for (int k = 0; k < 2; k++) wr(4'(`FCTS_ADDR_RISE_ACK + k), 32'h1);
        u_field.pulse(0, 4);
        for (int k = 0; k < 2; k++) begin
            rd(4'(`FCTS_ADDR_RISE_STAMP + k), d);
            `CHECK(d != v1[k], 1'b1)
        end
        wr(`FCTS_ADDR_CTRL, 32'h1c);
        rc(`FCTS_ADDR_STATUS, 32'h30, 32'h0);
        rd(`FCTS_ADDR_IRQ_STAT, d);
        wr(`FCTS_ADDR_FILTER, 32'h00000605);
        u_field.pulse(1, 4);
        rc(`FCTS_ADDR_STATUS, 32'h4, 32'h4);
        repeat (1000) @(posedge mclk);
        rc(`FCTS_ADDR_STATUS, 32'h4, 32'h0);
        wr(`FCTS_ADDR_FILTER, 32'h00000506);
        rd(`FCTS_ADDR_IRQ_STAT, d);
        u_field.pulse(0, 990);
        rc(`FCTS_ADDR_IRQ_STAT, 32'h6, 32'h0);
        u_field.pulse(0, 1010);
        rc(`FCTS_ADDR_IRQ_STAT, 32'h6, 32'h6);
        stop_test;
    end
endmodule
